/* design/rcb_config_bank.sv */
// Purpose: configuration command words of the buck regulator, read and written by code
// Assumes: frame logic delivers one-cycle read or write strobes with command code
// Notes: answer one cycle after the strobe; illegal values leave the word unchanged
`timescale 1ns/1ps
module rcb_config_bank
  import rcb_pkg::*;
(
  // clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        rst_i,
  // command requests from frame logic
  input  wire logic        cmd_wr_i,
  input  wire logic        cmd_rd_i,
  input  wire logic [7:0]  cmd_code_i,
  input  wire logic [15:0] cmd_wdata_i,
  // answer to frame logic
  output logic             cmd_ack_o,
  output logic [15:0]      cmd_rdata_o,
  // communication error flag and its clear
  input  wire logic        cml_clear_i,
  output logic             cml_error_o,
  // settings to the regulator core
  output rcb_cfg_s         cfg_o
);

  // map a command code to its register index
  function automatic logic [IW-1:0] find_reg(input logic [7:0] code);
    logic [IW-1:0] ix;
    ix = IX_NONE;
    for (int i = 0; i < NREG; i++) begin
      if (CMD_CODE[i] == code) begin
        ix = IW'(i);
      end
    end
    return ix;
  endfunction

  // check a value against the option set or range of its register
  function automatic logic value_ok(input logic [IW-1:0] ix, input logic [15:0] v);
    logic ok;
    ok = 1'b1;
    unique case (ix)
      IX_SLEW:  ok = (v == SLEW_0203) || (v == SLEW_1953) ||
                     (v == SLEW_2922) || (v == SLEW_9375);
      IX_LOOP:  ok = (v == LOOP_Q25) || (v == LOOP_Q50) || (v == LOOP_Q100);
      IX_ROLE:  ok = (v <= ROLE_MAX);
      IX_OCRSP: ok = ((v & RSP_MASK) == 16'h0000);
      IX_VORSP: ok = ((v & RSP_MASK) == 16'h0000);
      IX_VOVL:  ok = (v >= VOV_MIN) && (v <= VOV_MAX);
      IX_PEAK:  ok = (v >= PEAK_MIN) && (v <= PEAK_MAX);
      IX_NEGPK: ok = (v >= NEG_MIN) && (v <= NEG_MAX);
      IX_AVGW:  ok = (v[15:11] == AVG_EXP) && (v >= AVG_MIN) && (v <= AVG_MAX);
      default:  ok = 1'b1;
    endcase
    return ok;
  endfunction

  logic [15:0]   word_reg [NREG];
  logic [15:0]   rdata_reg;
  logic          ack_reg;
  logic          err_reg;

  // request decode
  wire  [IW-1:0] req_ix   = find_reg(cmd_code_i);
  wire           req_hit  = (req_ix != IX_NONE);
  wire  [15:0]   wr_val   = BYTE_REG[req_ix] ? {8'h00, cmd_wdata_i[7:0]} : cmd_wdata_i;
  wire           wr_legal = req_hit && value_ok(req_ix, wr_val);
  wire           wr_do    = cmd_wr_i && wr_legal;
  wire           rd_do    = cmd_rd_i && !cmd_wr_i;
  wire           bad_req  = (cmd_wr_i && !wr_legal) || (rd_do && !req_hit);
  wire  [15:0]   rd_val   = req_hit ? word_reg[req_ix] : 16'h0000;

  // keep old word on illegal write
  always_ff @(posedge sys_clk_i) begin
    for (int i = 0; i < NREG; i++) begin
      if (rst_i) begin
        word_reg[i] <= RST_VAL[i];
      end else if (wr_do && (req_ix == IW'(i))) begin
        word_reg[i] <= wr_val;
      end
    end
  end

  // answer strobe and read data
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      ack_reg   <= 1'b0;
      rdata_reg <= 16'h0000;
    end else begin
      ack_reg   <= cmd_wr_i || cmd_rd_i;
      rdata_reg <= rd_do ? rd_val : rdata_reg;
    end
  end

  // sticky error, new error beats clear
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      err_reg <= 1'b0;
    end else if (bad_req) begin
      err_reg <= 1'b1;
    end else if (cml_clear_i) begin
      err_reg <= 1'b0;
    end
  end

  assign cmd_ack_o   = ack_reg;
  assign cmd_rdata_o = rdata_reg;
  assign cml_error_o = err_reg;

  // settings fan-out
  assign cfg_o.output_voltage_ceiling         = word_reg[0];
  assign cfg_o.output_margin_upper_level      = word_reg[1];
  assign cfg_o.output_margin_lower_level      = word_reg[2];
  assign cfg_o.output_slew_rate_select        = word_reg[IX_SLEW];
  assign cfg_o.feedback_loop_scale            = word_reg[IX_LOOP];
  assign cfg_o.switching_frequency_set        = word_reg[5];
  assign cfg_o.input_turn_on_threshold        = word_reg[6];
  assign cfg_o.input_turn_off_threshold       = word_reg[7];
  assign cfg_o.multiphase_role_select         = rcb_role_e'(word_reg[IX_ROLE][1:0]);
  assign cfg_o.output_overvoltage_reaction    = word_reg[9][7:0];
  assign cfg_o.output_undervoltage_warn_level = word_reg[10];
  assign cfg_o.output_undervoltage_reaction   = word_reg[11][7:0];
  assign cfg_o.peak_overcurrent_level         = word_reg[IX_PEAK];
  assign cfg_o.peak_overcurrent_reaction      = word_reg[IX_OCRSP][7:0];
  assign cfg_o.average_current_warn_level     = word_reg[IX_AVGW];
  assign cfg_o.negative_peak_current_level    = word_reg[IX_NEGPK];
  assign cfg_o.overtemperature_fault_level    = word_reg[16];
  assign cfg_o.overtemperature_reaction       = word_reg[17][7:0];
  assign cfg_o.overtemperature_warn_level     = word_reg[18];
  assign cfg_o.input_overvoltage_level        = word_reg[IX_VOVL];
  assign cfg_o.input_overvoltage_reaction     = word_reg[IX_VORSP][7:0];
  assign cfg_o.startup_delay_time             = word_reg[21];
  assign cfg_o.startup_rise_time              = word_reg[22];
  assign cfg_o.startup_timeout_level          = word_reg[23];

  // checks on stored settings
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (rst_i);

  a_slew_legal: assert property (value_ok(IX_SLEW, word_reg[IX_SLEW]) &&
    ($past(rst_i) -> word_reg[IX_SLEW] == SLEW_0203)) else $error("slew illegal");
  a_loop_legal: assert property (value_ok(IX_LOOP, word_reg[IX_LOOP]) &&
    ($past(rst_i) -> word_reg[IX_LOOP] == LOOP_Q50)) else $error("loop illegal");
  a_role_legal: assert property ($past(rst_i) |-> word_reg[IX_ROLE] == 16'h0000 ##1
    word_reg[IX_ROLE] <= ROLE_MAX) else $error("role illegal");
  a_ocrsp_legal: assert property ((word_reg[IX_OCRSP] & RSP_MASK) == 16'h0000)
    else $error("oc reaction illegal");
  a_vin_ov_legal: assert property (word_reg[IX_VOVL] >= VOV_MIN &&
    word_reg[IX_VOVL] <= VOV_MAX && (word_reg[IX_VORSP] & RSP_MASK) == 16'h0000)
    else $error("vin ov illegal");
  a_peak_range: assert property (cmd_wr_i && cmd_code_i == CMD_CODE[IX_PEAK] &&
    cmd_wdata_i > PEAK_MAX |=> $stable(word_reg[IX_PEAK]) && cml_error_o)
    else $error("peak limit out of range taken");
  a_neg_range: assert property (word_reg[IX_NEGPK] >= NEG_MIN &&
    word_reg[IX_NEGPK] <= NEG_MAX) else $error("negative limit illegal");
  a_avg_range: assert property (value_ok(IX_AVGW, word_reg[IX_AVGW]))
    else $error("average warning illegal");
  // legal write lands and is read back
  a_write_land: assert property (cmd_wr_i && wr_legal ##1 cmd_rd_i && !cmd_wr_i &&
    cmd_code_i == $past(cmd_code_i) |=> cmd_rdata_o == $past(wr_val, 2))
    else $error("written word not read back");
  // answer timing
  a_ack_timing: assert property ((cmd_wr_i || cmd_rd_i) |=> cmd_ack_o ##1
    (!cmd_ack_o || $past(cmd_wr_i || cmd_rd_i))) else $error("answer timing wrong");

endmodule // rcb_config_bank

/* common/rcb_pkg.sv */
// Purpose: constants and types of the regulator configuration command bank
// Assumes: command frames are decoded upstream; one command word per request
// Notes on behaviour
// - slew select holds only 0.203, 1.953, 2.9218, 9.375 mV/us; reset 0.203
// - loop scale holds only 0.25, 0.5 or 1; reset is 0.5
// - multiphase role is standalone, leader, follower 0 or 180; reset standalone
// - peak overcurrent reaction: two ignores, latch-off, hiccup; reset latch-off
// - input overvoltage reaction four choices, reset recovery; level 18 to 24 V, 2 V
// - high side peak limit 1 A to 31 A, default 25 A
// - low side negative peak limit 5 A to 12 A, default 8 A
// - average current warning 62.5 mA steps over 1 A to 64 A, default 13 A
package rcb_pkg;

  localparam int NREG = 24;
  localparam int IW   = 5;

  // register indices used by the legality checks; IX_NONE marks an unmapped code
  localparam logic [IW-1:0] IX_SLEW  = 5'h03;
  localparam logic [IW-1:0] IX_LOOP  = 5'h04;
  localparam logic [IW-1:0] IX_ROLE  = 5'h08;
  localparam logic [IW-1:0] IX_OCRSP = 5'h0D;
  localparam logic [IW-1:0] IX_AVGW  = 5'h0E;
  localparam logic [IW-1:0] IX_NEGPK = 5'h0F;
  localparam logic [IW-1:0] IX_PEAK  = 5'h0C;
  localparam logic [IW-1:0] IX_VOVL  = 5'h13;
  localparam logic [IW-1:0] IX_VORSP = 5'h14;
  localparam logic [IW-1:0] IX_NONE  = 5'h1F;

  // command codes, in index order
  localparam logic [7:0] CMD_CODE [NREG] = '{
    8'h24, 8'h25, 8'h26, 8'h27, 8'h29, 8'h33, 8'h35, 8'h36,
    8'h37, 8'h41, 8'h43, 8'h45, 8'h46, 8'h47, 8'h4A, 8'h4B,
    8'h4F, 8'h50, 8'h51, 8'h55, 8'h56, 8'h60, 8'h61, 8'h62};

  // reset values, in index order
  localparam logic [15:0] RST_VAL [NREG] = '{
    16'h0B00, 16'h06CD, 16'h0667, 16'hD00D, 16'hF002, 16'h092C, 16'hF80C, 16'hF80B,
    16'h0000, 16'h0040, 16'h0067, 16'h0040, 16'h0019, 16'h0080, 16'hE0D0, 16'h0008,
    16'h008C, 16'h00C0, 16'h0073, 16'h080A, 16'h00C0, 16'h0001, 16'h0005, 16'h0806};

  // one marks a byte wide register
  localparam logic [NREG-1:0] BYTE_REG = 24'h122A00;

  // slew options, linear format with 2^-6 scale
  localparam logic [15:0] SLEW_0203 = 16'hD00D;
  localparam logic [15:0] SLEW_1953 = 16'hD07D;
  localparam logic [15:0] SLEW_2922 = 16'hD0BB;
  localparam logic [15:0] SLEW_9375 = 16'hD258;
  // loop scale options, 2^-2 scale
  localparam logic [15:0] LOOP_Q25  = 16'hF001;
  localparam logic [15:0] LOOP_Q50  = 16'hF002;
  localparam logic [15:0] LOOP_Q100 = 16'hF004;
  // highest multiphase role code
  localparam logic [15:0] ROLE_MAX  = 16'h0003;
  // reaction codes keep the choice in bits 7:6 only
  localparam logic [15:0] RSP_MASK  = 16'hFF3F;
  // input overvoltage level: 2 V units, 18 V to 24 V
  localparam logic [15:0] VOV_MIN   = 16'h0809;
  localparam logic [15:0] VOV_MAX   = 16'h080C;
  // peak limits in whole amperes
  localparam logic [15:0] PEAK_MIN  = 16'h0001;
  localparam logic [15:0] PEAK_MAX  = 16'h001F;
  localparam logic [15:0] NEG_MIN   = 16'h0005;
  localparam logic [15:0] NEG_MAX   = 16'h000C;
  // average warning, 1/16 A units, 1 A to 64 A
  localparam logic [15:0] AVG_MIN   = 16'hE010;
  localparam logic [15:0] AVG_MAX   = 16'hE400;
  localparam logic [4:0]  AVG_EXP   = 5'h1C;

  typedef enum logic [1:0] {
    RCB_ROLE_ALONE,
    RCB_ROLE_LEADER,
    RCB_ROLE_FOLLOW0,
    RCB_ROLE_FOLLOW180
  } rcb_role_e;

  // settings handed to the regulator core
  typedef struct packed {
    logic [15:0] output_voltage_ceiling;
    logic [15:0] output_margin_upper_level;
    logic [15:0] output_margin_lower_level;
    logic [15:0] output_slew_rate_select;
    logic [15:0] feedback_loop_scale;
    logic [15:0] switching_frequency_set;
    logic [15:0] input_turn_on_threshold;
    logic [15:0] input_turn_off_threshold;
    rcb_role_e   multiphase_role_select;
    logic [7:0]  output_overvoltage_reaction;
    logic [15:0] output_undervoltage_warn_level;
    logic [7:0]  output_undervoltage_reaction;
    logic [15:0] peak_overcurrent_level;
    logic [7:0]  peak_overcurrent_reaction;
    logic [15:0] average_current_warn_level;
    logic [15:0] negative_peak_current_level;
    logic [15:0] overtemperature_fault_level;
    logic [7:0]  overtemperature_reaction;
    logic [15:0] overtemperature_warn_level;
    logic [15:0] input_overvoltage_level;
    logic [7:0]  input_overvoltage_reaction;
    logic [15:0] startup_delay_time;
    logic [15:0] startup_rise_time;
    logic [15:0] startup_timeout_level;
  } rcb_cfg_s;

endpackage

/* verification/rcb_host_model.sv */
// Purpose: frame logic stand-in that issues command words to the bank
// Assumes: one-cycle strobes launched at the falling edge
// Notes: released code and data lines show the inverse of the last value
`timescale 1ns/1ps
module rcb_host_model (
  // clock
  input  wire logic        sys_clk_i,
  // answer from the bank
  input  wire logic        cmd_ack_i,
  input  wire logic [15:0] cmd_rdata_i,
  // requests to the bank
  output logic             cmd_wr_o,
  output logic             cmd_rd_o,
  output logic [7:0]       cmd_code_o,
  output logic [15:0]      cmd_wdata_o,
  output logic             cml_clear_o
);
  // idle lines at time zero
  initial begin
    cmd_wr_o    = 1'b0;
    cmd_rd_o    = 1'b0;
    cmd_code_o  = 8'h00;
    cmd_wdata_o = 16'h0000;
    cml_clear_o = 1'b0;
  end
  // one request; the answer is taken at the next falling edge
  task automatic xfer(input logic wr, input logic [7:0] c, input logic [15:0] d,
                      output logic ack, output logic [15:0] rdata);
    @(negedge sys_clk_i);
    cmd_wr_o    = wr;
    cmd_rd_o    = !wr;
    cmd_code_o  = c;
    cmd_wdata_o = d;
    @(negedge sys_clk_i);
    ack         = cmd_ack_i;
    rdata       = cmd_rdata_i;
    cmd_wr_o    = 1'b0;
    cmd_rd_o    = 1'b0;
    cmd_code_o  = ~c;
    cmd_wdata_o = ~d;
  endtask
  // write then read of the same code on the very next edge
  task automatic pair(input logic [7:0] c, input logic [15:0] d,
                      output logic [15:0] rdata);
    @(negedge sys_clk_i);
    cmd_wr_o    = 1'b1;
    cmd_rd_o    = 1'b0;
    cmd_code_o  = c;
    cmd_wdata_o = d;
    @(negedge sys_clk_i);
    cmd_wr_o    = 1'b0;
    cmd_rd_o    = 1'b1;
    @(negedge sys_clk_i);
    rdata       = cmd_rdata_i;
    cmd_rd_o    = 1'b0;
    cmd_code_o  = ~c;
    cmd_wdata_o = ~d;
  endtask
  // one-cycle clear of the error flag
  task automatic clear();
    @(negedge sys_clk_i);
    cml_clear_o = 1'b1;
    @(negedge sys_clk_i);
    cml_clear_o = 1'b0;
  endtask
endmodule // rcb_host_model

/* verification/tb_regulator_config_command_bank.sv */
// Purpose: self-checking bench of the configuration command bank
// Assumes: host model drives requests at the falling edge
// Notes: legal sets, range limits, refusals and reset values
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin mismatches++; \
  $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module tb_regulator_config_command_bank;
  import rcb_pkg::*;
  logic        sys_clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cmd_wr_i, cmd_rd_i, cml_clear_i, cmd_ack_o, cml_error_o;
  logic [7:0]  cmd_code_i;
  logic [15:0] cmd_wdata_i, cmd_rdata_o;
  rcb_cfg_s    cfg_o;
  int          mismatches = 0;
  int          tests_run = 0;
  int          cycles = 0;
  localparam logic [15:0] SLEW [4] = '{SLEW_0203, SLEW_1953, SLEW_2922, SLEW_9375};
  localparam logic [15:0] LOOPV [3] = '{LOOP_Q25, LOOP_Q50, LOOP_Q100};
  localparam logic [15:0] RSP [4] = '{16'h0000, 16'h0040, 16'h0080, 16'h00C0};
  // code, word, accepted
  localparam logic [24:0] RNG [22] = '{
    {8'h55, VOV_MIN, 1'b1}, {8'h55, VOV_MAX, 1'b1}, {8'h55, 16'h0808, 1'b0},
    {8'h55, 16'h080D, 1'b0}, {8'h46, PEAK_MIN, 1'b1}, {8'h46, PEAK_MAX, 1'b1},
    {8'h46, 16'h0000, 1'b0}, {8'h46, 16'h0020, 1'b0}, {8'h4B, NEG_MIN, 1'b1},
    {8'h4B, NEG_MAX, 1'b1}, {8'h4B, 16'h0004, 1'b0}, {8'h4B, 16'h000D, 1'b0},
    {8'h4A, AVG_MIN, 1'b1}, {8'h4A, AVG_MAX, 1'b1}, {8'h4A, 16'hE00F, 1'b0},
    {8'h4A, 16'hE401, 1'b0}, {8'h4A, 16'hE810, 1'b0}, {8'h27, 16'hD00E, 1'b0},
    {8'h29, 16'hF003, 1'b0}, {8'h37, 16'h0004, 1'b0}, {8'h47, 16'h0041, 1'b0},
    {8'h56, 16'h0020, 1'b0}};
  // clock
  always #10 sys_clk_i = ~sys_clk_i;
  rcb_config_bank dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .cmd_wr_i(cmd_wr_i),
    .cmd_rd_i(cmd_rd_i), .cmd_code_i(cmd_code_i), .cmd_wdata_i(cmd_wdata_i),
    .cmd_ack_o(cmd_ack_o), .cmd_rdata_o(cmd_rdata_o), .cml_clear_i(cml_clear_i),
    .cml_error_o(cml_error_o), .cfg_o(cfg_o));
  rcb_host_model host (.sys_clk_i(sys_clk_i), .cmd_ack_i(cmd_ack_o),
    .cmd_rdata_i(cmd_rdata_o), .cmd_wr_o(cmd_wr_i), .cmd_rd_o(cmd_rd_i),
    .cmd_code_o(cmd_code_i), .cmd_wdata_o(cmd_wdata_i), .cml_clear_o(cml_clear_i));
  // verdict and end of run
  task automatic report_and_stop();
    $display("tests_run %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // hang guard
  always @(posedge sys_clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      report_and_stop();
    end
  end
  task automatic do_reset();
    rst_i = 1'b1;
    repeat (3) @(negedge sys_clk_i);
    rst_i = 1'b0;
  endtask
  // write, check refusal flag, read back new or old word, clear flag
  task automatic try_wr(input logic [7:0] c, input logic [15:0] d, input logic ok);
    logic a;
    logic [15:0] old, rb;
    host.xfer(1'b0, c, 16'h0000, a, old);
    host.xfer(1'b1, c, d, a, rb);
    `CHK(a, 1'b1)
    `CHK(cml_error_o, !ok)
    host.xfer(1'b0, c, 16'h0000, a, rb);
    `CHK(rb, ok ? d : old)
    host.clear();
  endtask
  task automatic t_reset_values();
    logic a;
    logic [15:0] rb;
    for (int i = 0; i < NREG; i++) begin
      host.xfer(1'b0, CMD_CODE[i], 16'h0000, a, rb);
      `CHK(rb, RST_VAL[i])
    end
    `CHK(cfg_o.multiphase_role_select, RCB_ROLE_ALONE)
  endtask
  task automatic t_legal_options();
    foreach (SLEW[i]) try_wr(8'h27, SLEW[i], 1'b1);
    foreach (LOOPV[i]) try_wr(8'h29, LOOPV[i], 1'b1);
    foreach (RSP[i]) try_wr(8'h47, RSP[i], 1'b1);
    foreach (RSP[i]) try_wr(8'h56, RSP[i], 1'b1);
    for (int i = 0; i < 4; i++) begin
      try_wr(8'h37, 16'(i), 1'b1);
      `CHK(cfg_o.multiphase_role_select, rcb_role_e'(i))
    end
  endtask
  task automatic t_ranges();
    foreach (RNG[i]) try_wr(RNG[i][24:17], RNG[i][16:1], RNG[i][0]);
  endtask
  task automatic t_unmapped();
    logic a;
    logic [15:0] rb;
    host.xfer(1'b0, 8'h28, 16'h0000, a, rb);
    `CHK(rb, 16'h0000)
    `CHK(cml_error_o, 1'b1)
    host.clear();
    `CHK(cml_error_o, 1'b0)
  endtask
  // back to back write and read; byte register keeps only its low byte
  task automatic t_back_to_back();
    logic [15:0] rb;
    host.pair(8'h46, 16'h0007, rb);
    `CHK(rb, 16'h0007)
    host.pair(8'h45, 16'hAB40, rb);
    `CHK(rb, 16'h0040)
  endtask
  task automatic t_mid_reset();
    logic a;
    logic [15:0] rb;
    try_wr(8'h27, SLEW_9375, 1'b1);
    try_wr(8'h29, LOOP_Q100, 1'b1);
    host.xfer(1'b1, 8'h46, 16'h0000, a, rb);
    do_reset();
    `CHK(cml_error_o, 1'b0)
    `CHK(cfg_o.output_slew_rate_select, SLEW_0203)
    `CHK(cfg_o.feedback_loop_scale, LOOP_Q50)
    `CHK(cfg_o.peak_overcurrent_level, 16'h0019)
  endtask
  initial begin
    do_reset();
    t_reset_values();
    t_legal_options();
    t_ranges();
    t_unmapped();
    t_back_to_back();
    t_mid_reset();
    report_and_stop();
  end
endmodule // tb_regulator_config_command_bank
